// ### addressing_pkg.sv
// Shared constants and types for operand addressing and repeat control.
// Assumes a 16-bit core with eight auxiliary registers and one clock.
package addressing_pkg;

  // Data path and register file geometry
  localparam int WORD_W = 16;          // Operand and address width
  localparam int AR_COUNT = 8;         // Auxiliary registers in the file
  localparam int AR_IDX_W = 3;         // Width of the register pointer
  localparam int DP_W = 9;             // Data page pointer width
  localparam int DIRECT_OFS_W = 7;     // In-page offset in the instruction
  localparam int SHORT_IMM_W = 8;      // Short immediate field width
  localparam int RPT_W = 16;           // Repeat count register width
  localparam int IRQ_COUNT = 4;        // Maskable interrupt lines

  // Reset values
  localparam logic [RPT_W-1:0] RPT_COUNT_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] AR_RESET = 16'h0000;
  localparam logic [AR_IDX_W-1:0] ARP_RESET = 3'h0;
  localparam logic [DP_W-1:0] DP_RESET = 9'h000;

  // Register zero doubles as the index register
  localparam logic [AR_IDX_W-1:0] INDEX_REG_IDX = 3'h0;

  // Step of plain increment or decrement
  localparam logic [WORD_W-1:0] AR_STEP = 16'h0001;
  localparam logic [RPT_W-1:0] RPT_STEP = 16'h0001;

  // Program words taken by the two immediate forms
  localparam logic [1:0] WORDS_SHORT = 2'h1;
  localparam logic [1:0] WORDS_LONG = 2'h2;

  // Operand addressing mode presented by the instruction decoder
  typedef enum logic [2:0] {
    mode_direct,
    mode_indirect,
    mode_short_imm,
    mode_long_imm,
    mode_register
  } addr_mode_t;

  // The seven indirect variants
  typedef enum logic [2:0] {
    ind_none,
    ind_inc,
    ind_dec,
    ind_add_index,
    ind_sub_index,
    ind_bitrev_inc,
    ind_bitrev_dec
  } ind_op_t;

endpackage

// ### aux_register_file.sv
// Eight auxiliary registers, their pointer and the indirect update logic.
// Assumes the caller raises op_en only in the instruction's own cycle.
`timescale 1ns/1ps
`default_nettype none
module aux_register_file
  import addressing_pkg::*;
(
  input wire logic core_clk,                      // Core clock
  input wire logic rst_b,                         // Async reset, low
  input wire logic op_en,                         // Apply indirect update
  input wire addressing_pkg::ind_op_t op,         // Indirect variant
  input wire logic arp_load,                      // Reload the pointer
  input wire logic [addressing_pkg::AR_IDX_W-1:0] arp_value, // New pointer
  input wire logic wr_en,                         // Direct register write
  input wire logic [addressing_pkg::AR_IDX_W-1:0] wr_idx, // Write target
  input wire logic [addressing_pkg::WORD_W-1:0] wr_data, // Write data
  input wire logic [addressing_pkg::AR_IDX_W-1:0] rd_idx, // Read select
  output logic [addressing_pkg::WORD_W-1:0] auxiliary_register_value, // Cur
  output logic [addressing_pkg::WORD_W-1:0] rd_value, // Selected register
  output logic [addressing_pkg::AR_IDX_W-1:0] aux_register_pointer // Ptr
);

  logic [WORD_W-1:0] ar_q [AR_COUNT]; // Register storage
  logic [WORD_W-1:0] ar_d [AR_COUNT]; // Next register values
  logic [AR_IDX_W-1:0] arp_q; // Current pointer
  logic [AR_IDX_W-1:0] arp_d; // Next pointer
  logic [WORD_W-1:0] cur; // Register the pointer selects
  logic [WORD_W-1:0] index_value; // Index register contents
  logic [WORD_W-1:0] next_cur; // Modified current register

  // Mirror a word so carries run from the top bit downward
  function automatic logic [WORD_W-1:0] bit_rev(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++) begin
      r[i] = v[WORD_W-1-i];
    end
    return r;
  endfunction

  assign cur = ar_q[arp_q];
  assign index_value = ar_q[INDEX_REG_IDX];

  // Modified value of the current register, one per variant
  always_comb begin
    next_cur = cur;
    case (op)
      ind_none: next_cur = cur;
      ind_inc: next_cur = cur + AR_STEP;
      ind_dec: next_cur = cur - AR_STEP;
      ind_add_index: next_cur = cur + index_value;
      ind_sub_index: next_cur = cur - index_value;
      // Reverse, add normally, reverse back: reversed carry path
      ind_bitrev_inc: begin
        next_cur = bit_rev(bit_rev(cur) + bit_rev(index_value));
      end
      ind_bitrev_dec: begin
        next_cur = bit_rev(bit_rev(cur) - bit_rev(index_value));
      end
      default: next_cur = cur;
    endcase
    // Pointer changes only after the current register was used
    arp_d = arp_load ? arp_value : arp_q;
  end

  // Per-register next value; an explicit write beats the indirect update
  for (genvar g = 0; g < AR_COUNT; g++) begin : g_ar
    assign ar_d[g] = (wr_en && wr_idx == AR_IDX_W'(g)) ? wr_data :
                     (op_en && arp_q == AR_IDX_W'(g)) ? next_cur :
                     ar_q[g];
  end

  // Storage and pointer registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < AR_COUNT; i++) begin
        ar_q[i] <= AR_RESET;
      end
      arp_q <= ARP_RESET;
    end else begin
      for (int i = 0; i < AR_COUNT; i++) begin
        ar_q[i] <= ar_d[i];
      end
      arp_q <= arp_d;
    end
  end

  assign auxiliary_register_value = cur;
  assign rd_value = ar_q[rd_idx];
  assign aux_register_pointer = arp_q;

endmodule // aux_register_file
`default_nettype wire

// ### operand_addressing_and_repeat_control.sv
// Operand address generation and instruction repeat control.
// Assumes the decoder presents one decoded word per cycle at most and
// holds off new words while fetch_hold_q is high.
`timescale 1ns/1ps
`default_nettype none
module operand_addressing_and_repeat_control
  import addressing_pkg::*;
(
  input wire logic core_clk,                      // Core clock, 10 MHz
  input wire logic rst_b,                         // Async reset, low
  input wire logic instr_valid,                   // Decoded word present
  input wire logic [addressing_pkg::WORD_W-1:0] instr_word, // First word
  input wire addressing_pkg::addr_mode_t addr_mode, // Operand mode
  input wire addressing_pkg::ind_op_t ind_op,     // Indirect variant
  input wire logic is_repeat,                     // Repeat instruction
  input wire logic repeatable,                    // May run under repeat
  input wire logic [addressing_pkg::WORD_W-1:0] mem_word, // Addressed word
  input wire logic second_valid,                  // Second word present
  input wire logic [addressing_pkg::WORD_W-1:0] second_word, // Second word
  input wire logic [addressing_pkg::AR_IDX_W-1:0] reg_sel, // Named register
  input wire logic reg_implied,                   // Opcode implies buffer
  input wire logic [addressing_pkg::WORD_W-1:0] accumulator_buffer, // Buf
  input wire logic arp_load,                      // Reload register pointer
  input wire logic [addressing_pkg::AR_IDX_W-1:0] arp_value, // New pointer
  input wire logic ar_wr_en,                      // Write an aux register
  input wire logic [addressing_pkg::AR_IDX_W-1:0] ar_wr_idx, // Write target
  input wire logic [addressing_pkg::WORD_W-1:0] ar_wr_data, // Write data
  input wire logic dp_load,                       // Load data page pointer
  input wire logic [addressing_pkg::DP_W-1:0] dp_value, // New page
  input wire logic [addressing_pkg::IRQ_COUNT-1:0] irq_req, // Raw interrupts
  input wire logic nmi_req,                       // Raw non-maskable request
  output logic [addressing_pkg::WORD_W-1:0] data_addr_q, // Data address
  output logic addr_valid_q,                      // Address valid pulse
  output logic [addressing_pkg::WORD_W-1:0] operand_q, // Immediate/reg data
  output logic operand_valid_q,                   // Operand valid pulse
  output logic exec_q,                            // One execution pulse
  output logic fetch_second_q,                    // Request second word
  output logic [1:0] instr_words_q,               // Words of last instr
  output logic fetch_hold_q,                      // Decoder must stall
  output logic repeat_active_q,                   // Repeat loop running
  output logic repeat_iter_q,                     // One repeat iteration
  output logic int_mask_q,                        // Interrupts masked
  output logic [addressing_pkg::IRQ_COUNT-1:0] irq_out_q, // Gated requests
  output logic nmi_out_q,                         // Gated non-maskable
  output logic [addressing_pkg::RPT_W-1:0] repeat_count_register, // Count
  output logic [addressing_pkg::AR_IDX_W-1:0] aux_register_pointer // Ptr
);

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,    // Waiting for an instruction
    st_second,  // Waiting for the long immediate word
    st_armed,   // Repeat decoded, waiting for its target
    st_repeat   // Target running one iteration per cycle
  } seq_state_t;

  seq_state_t state_q; // Sequencer state
  seq_state_t state_d; // Next sequencer state

  // Copy of the repeated instruction, replayed every iteration after the first
  logic [WORD_W-1:0] hold_word_q; // Held first word
  logic [WORD_W-1:0] hold_word_d; // Next held word
  addr_mode_t hold_mode_q; // Held mode
  addr_mode_t hold_mode_d; // Next held mode
  ind_op_t hold_op_q; // Held indirect variant
  ind_op_t hold_op_d; // Next held variant
  logic [AR_IDX_W-1:0] hold_reg_q; // Held register select
  logic [AR_IDX_W-1:0] hold_reg_d; // Next held select
  logic hold_impl_q; // Held implied flag
  logic hold_impl_d; // Next implied flag

  logic [DP_W-1:0] dp_q; // Data page pointer
  logic [DP_W-1:0] dp_d; // Next page pointer

  // Next values of registered outputs
  logic [WORD_W-1:0] data_addr_d; // Next address
  logic addr_valid_d; // Next address strobe
  logic [WORD_W-1:0] operand_d; // Next operand
  logic operand_valid_d; // Next operand strobe
  logic exec_d; // Next execution pulse
  logic [1:0] instr_words_d; // Next word count
  logic repeat_iter_d; // Next iteration pulse
  logic mask_d; // Next interrupt mask

  // Working signals of the sequencer
  logic ex_go; // Execute the selected instruction now
  addr_mode_t sel_mode; // Mode in effect this cycle
  logic [WORD_W-1:0] sel_word; // Word in effect this cycle
  ind_op_t sel_op; // Indirect variant in effect
  logic [AR_IDX_W-1:0] sel_reg; // Register select in effect
  logic sel_impl; // Implied flag in effect
  logic op_en; // Update the current aux register
  logic rpt_load; // Load the repeat count
  logic [RPT_W-1:0] rpt_value; // Count to load
  logic rpt_step; // Consume one repeat
  logic rpt_last; // No repeats left

  logic [WORD_W-1:0] ar_cur; // Current aux register
  logic [WORD_W-1:0] ar_rd; // Register-mode aux operand

  // Aux register file: address taken now, update lands at the edge
  aux_register_file u_ar (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .op_en(op_en),
    .op(sel_op),
    .arp_load(arp_load),
    .arp_value(arp_value),
    .wr_en(ar_wr_en),
    .wr_idx(ar_wr_idx),
    .wr_data(ar_wr_data),
    .rd_idx(sel_reg),
    .auxiliary_register_value(ar_cur),
    .rd_value(ar_rd),
    .aux_register_pointer(aux_register_pointer)
  );

  // Repeat count register
  repeat_counter u_rpt (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load_en(rpt_load),
    .load_value(rpt_value),
    .step(rpt_step),
    .repeat_count_register(repeat_count_register),
    .last(rpt_last)
  );

  // Sequencer: instruction intake, second word fetch and repeat loop
  always_comb begin
    state_d = state_q;
    hold_word_d = hold_word_q;
    hold_mode_d = hold_mode_q;
    hold_op_d = hold_op_q;
    hold_reg_d = hold_reg_q;
    hold_impl_d = hold_impl_q;
    instr_words_d = instr_words_q;
    ex_go = 1'b0;
    rpt_load = 1'b0;
    rpt_step = 1'b0;
    repeat_iter_d = 1'b0;
    sel_mode = addr_mode;
    sel_word = instr_word;
    sel_op = ind_op;
    sel_reg = reg_sel;
    sel_impl = reg_implied;
    // Count source follows the repeat instruction's own mode
    if (addr_mode == mode_short_imm) begin
      rpt_value = {{(RPT_W-SHORT_IMM_W){1'b0}},
                   instr_word[SHORT_IMM_W-1:0]};
    end else begin
      rpt_value = mem_word;
    end
    case (state_q)
      st_idle: begin
        if (instr_valid) begin
          // Word count follows the immediate form
          instr_words_d = (addr_mode == mode_long_imm) ?
                          WORDS_LONG : WORDS_SHORT;
          if (is_repeat) begin
            rpt_load = 1'b1;
            ex_go = 1'b1;
            state_d = st_armed;
          end else if (addr_mode == mode_long_imm) begin
            state_d = st_second;
          end else begin
            ex_go = 1'b1;
          end
        end
      end
      st_second: begin
        // Operand only once the second word arrives
        if (second_valid) begin
          sel_mode = mode_long_imm;
          ex_go = 1'b1;
          state_d = st_idle;
        end
      end
      st_armed: begin
        if (instr_valid) begin
          instr_words_d = (addr_mode == mode_long_imm) ?
                          WORDS_LONG : WORDS_SHORT;
          if (repeatable && addr_mode != mode_long_imm) begin
            // First iteration now, the rest replayed from the copy
            hold_word_d = instr_word;
            hold_mode_d = addr_mode;
            hold_op_d = ind_op;
            hold_reg_d = reg_sel;
            hold_impl_d = reg_implied;
            ex_go = 1'b1;
            repeat_iter_d = 1'b1;
            if (rpt_last) begin
              state_d = st_idle;
            end else begin
              rpt_step = 1'b1;
              state_d = st_repeat;
            end
          end else if (addr_mode == mode_long_imm) begin
            // Not repeatable: run once, loop ends here
            state_d = st_second;
          end else begin
            ex_go = 1'b1;
            state_d = st_idle;
          end
        end
      end
      st_repeat: begin
        // One iteration every cycle, new words are ignored meanwhile
        sel_mode = hold_mode_q;
        sel_word = hold_word_q;
        sel_op = hold_op_q;
        sel_reg = hold_reg_q;
        sel_impl = hold_impl_q;
        ex_go = 1'b1;
        repeat_iter_d = 1'b1;
        if (rpt_last) begin
          state_d = st_idle;
        end else begin
          rpt_step = 1'b1;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
    // Masking from the decode of the repeat to the last iteration
    mask_d = (state_d == st_armed) || (state_d == st_repeat);
  end

  // Operand and address formation for the instruction in effect
  always_comb begin
    data_addr_d = data_addr_q;
    operand_d = operand_q;
    addr_valid_d = 1'b0;
    operand_valid_d = 1'b0;
    op_en = 1'b0;
    exec_d = ex_go;
    dp_d = dp_load ? dp_value : dp_q;
    if (ex_go) begin
      case (sel_mode)
        mode_direct: begin
          data_addr_d = {dp_q, sel_word[DIRECT_OFS_W-1:0]};
          addr_valid_d = 1'b1;
        end
        mode_indirect: begin
          // Address is the register before its modification
          data_addr_d = ar_cur;
          addr_valid_d = 1'b1;
          op_en = 1'b1;
        end
        mode_short_imm: begin
          operand_d = {{(WORD_W-SHORT_IMM_W){1'b0}},
                       sel_word[SHORT_IMM_W-1:0]};
          operand_valid_d = 1'b1;
        end
        mode_long_imm: begin
          operand_d = second_word;
          operand_valid_d = 1'b1;
        end
        mode_register: begin
          operand_d = sel_impl ? accumulator_buffer : ar_rd;
          operand_valid_d = 1'b1;
        end
        default: begin
          addr_valid_d = 1'b0;
        end
      endcase
    end
  end

  // Sequencer and output registers; the count and pointer outputs come from the submodules
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_idle;
      hold_word_q <= '0;
      hold_mode_q <= mode_direct;
      hold_op_q <= ind_none;
      hold_reg_q <= '0;
      hold_impl_q <= 1'b0;
      dp_q <= DP_RESET;
      data_addr_q <= '0;
      addr_valid_q <= 1'b0;
      operand_q <= '0;
      operand_valid_q <= 1'b0;
      exec_q <= 1'b0;
      fetch_second_q <= 1'b0;
      instr_words_q <= WORDS_SHORT;
      fetch_hold_q <= 1'b0;
      repeat_active_q <= 1'b0;
      repeat_iter_q <= 1'b0;
      int_mask_q <= 1'b0;
      irq_out_q <= '0;
      nmi_out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_word_q <= hold_word_d;
      hold_mode_q <= hold_mode_d;
      hold_op_q <= hold_op_d;
      hold_reg_q <= hold_reg_d;
      hold_impl_q <= hold_impl_d;
      dp_q <= dp_d;
      data_addr_q <= data_addr_d;
      addr_valid_q <= addr_valid_d;
      operand_q <= operand_d;
      operand_valid_q <= operand_valid_d;
      exec_q <= exec_d;
      fetch_second_q <= (state_d == st_second);
      instr_words_q <= instr_words_d;
      fetch_hold_q <= (state_d == st_repeat);
      repeat_active_q <= (state_d == st_repeat);
      repeat_iter_q <= repeat_iter_d;
      int_mask_q <= mask_d;
      // Non-maskable is gated as well; reset is not an interrupt here
      irq_out_q <= mask_d ? '0 : irq_req;
      nmi_out_q <= mask_d ? 1'b0 : nmi_req;
    end
  end

endmodule // operand_addressing_and_repeat_control
`default_nettype wire

// ### operand_addressing_and_repeat_control_assertions.sv
// Checker for addressing and repeat control, bound to the top module.
// Assumes it sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module addressing_checker
  import addressing_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic instr_valid, // Word present
  input wire logic [15:0] instr_word, // First word
  input wire addressing_pkg::addr_mode_t addr_mode, // Mode
  input wire logic is_repeat, // Repeat instruction
  input wire logic [15:0] mem_word, // Addressed word
  input wire logic second_valid, // Second word present
  input wire logic [15:0] second_word, // Second word
  input wire logic [15:0] data_addr_q, // Address
  input wire logic addr_valid_q, // Address pulse
  input wire logic [15:0] operand_q, // Operand
  input wire logic operand_valid_q, // Operand pulse
  input wire logic fetch_second_q, // Waiting second word
  input wire logic [1:0] instr_words_q, // Word count
  input wire logic fetch_hold_q, // Decoder stalled
  input wire logic repeat_iter_q, // Iteration pulse
  input wire logic int_mask_q, // Masked
  input wire logic [3:0] irq_out_q, // Gated requests
  input wire logic nmi_out_q, // Gated non-maskable
  input wire logic [15:0] repeat_count_register // Count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic take; // Word accepted at this edge
  assign take = instr_valid && !fetch_second_q && !fetch_hold_q;
  // Plain instruction and repeat instruction taken
  sequence s_op(addr_mode_t m);
    take && !is_repeat && addr_mode == m;
  endsequence
  sequence s_rpt(addr_mode_t m);
    take && is_repeat && addr_mode == m;
  endsequence
  property p_direct;
    s_op(mode_direct) |=> addr_valid_q
      && data_addr_q[6:0] == $past(instr_word[6:0]);
  endproperty
  property p_short;
    s_op(mode_short_imm) |=> operand_valid_q && instr_words_q == WORDS_SHORT
      && operand_q == {8'h00, $past(instr_word[7:0])};
  endproperty
  property p_long;
    s_op(mode_long_imm) |=> fetch_second_q && instr_words_q == WORDS_LONG;
  endproperty
  property p_second;
    fetch_second_q && second_valid |=> operand_valid_q && !fetch_second_q
      && operand_q == $past(second_word);
  endproperty
  property p_rpt_short;
    s_rpt(mode_short_imm) |=> int_mask_q
      && repeat_count_register == {8'h00, $past(instr_word[7:0])};
  endproperty
  property p_rpt_mem;
    s_rpt(mode_direct) |=> repeat_count_register == $past(mem_word);
  endproperty
  property p_gate;
    int_mask_q |-> irq_out_q == 4'h0 && !nmi_out_q;
  endproperty
  property p_chain;
    repeat_iter_q && fetch_hold_q |=> repeat_iter_q;
  endproperty
  property p_end;
    $fell(fetch_hold_q) |-> repeat_iter_q && !int_mask_q
      && repeat_count_register == 16'h0000;
  endproperty
  // Reset must clear the count, so this one is never disabled
  property p_reset;
    @(posedge core_clk) disable iff (1'b0)
      !rst_b |-> repeat_count_register == RPT_COUNT_RESET;
  endproperty
  a_direct: assert property (p_direct) else $error("direct addr");
  a_short: assert property (p_short) else $error("short imm");
  a_long: assert property (p_long) else $error("long fetch");
  a_second: assert property (p_second) else $error("long imm");
  a_rpt_short: assert property (p_rpt_short) else $error("rpt imm");
  a_rpt_mem: assert property (p_rpt_mem) else $error("rpt mem");
  a_gate: assert property (p_gate) else $error("irq leak");
  a_chain: assert property (p_chain) else $error("iter gap");
  a_end: assert property (p_end) else $error("loop end");
  a_reset: assert property (p_reset) else $error("count reset");
endmodule // addressing_checker
bind operand_addressing_and_repeat_control addressing_checker u_chk (.*);
`default_nettype wire

// ### operand_addressing_and_repeat_control_tb_top.sv
// Self-checking bench for addressing and repeat control.
// Assumes inputs change 5 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module operand_addressing_and_repeat_control_tb_top;
  import addressing_pkg::*;
  logic core_clk, rst_b, instr_valid, is_repeat, repeatable, second_valid;
  logic reg_implied, arp_load, ar_wr_en, dp_load, nmi_req;
  logic [15:0] instr_word, mem_word, second_word, accumulator_buffer;
  logic [15:0] ar_wr_data, data_addr_q, operand_q, repeat_count_register;
  logic [2:0] reg_sel, arp_value, ar_wr_idx, aux_register_pointer;
  logic [8:0] dp_value;
  logic [3:0] irq_req, irq_out_q;
  logic [1:0] instr_words_q;
  logic addr_valid_q, operand_valid_q, exec_q, fetch_second_q, fetch_hold_q;
  logic repeat_active_q, repeat_iter_q, int_mask_q, nmi_out_q;
  addr_mode_t addr_mode;
  ind_op_t ind_op;
  int errors, checked, cycles;
  operand_addressing_and_repeat_control DUT (.*);
  // Free-running 10 MHz clock
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // Hang guard, far above the planned run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc();
    @(posedge core_clk);
    #5;
  endtask
  // Present one word; strobe stays up for back-to-back use
  task automatic go(input addr_mode_t m, input logic [15:0] w);
    addr_mode = m;
    instr_word = w;
    instr_valid = 1;
    cyc();
  endtask
  task automatic stop();
    instr_valid = 0;
    arp_load = 0;
    cyc();
  endtask
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    ar_wr_en = 1;
    ar_wr_idx = i;
    ar_wr_data = d;
    cyc();
    ar_wr_en = 0;
    cyc();
  endtask
  function automatic logic [15:0] rv(input logic [15:0] v);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = v[15-i];
    return r;
  endfunction
  // Direct paging, immediates and a refused word
  task automatic t_direct_imm();
    dp_load = 1;
    dp_value = 9'h1a5;
    cyc();
    dp_load = 0;
    go(mode_direct, 16'hfff3);
    chk(data_addr_q, {9'h1a5, 7'h73});
    go(mode_short_imm, 16'h12ab);
    chk(operand_q, 16'h00ab);
    chk(instr_words_q, 16'h1);
    go(mode_long_imm, 16'h0000);
    chk(instr_words_q, 16'h2);
    go(mode_direct, 16'h0011);
    chk(addr_valid_q, 16'h0);
    stop();
    second_valid = 1;
    second_word = 16'hbeef;
    cyc();
    second_valid = 0;
    chk(operand_q, 16'hbeef);
  endtask
  // All indirect variants on register three, then register operands
  task automatic t_indirect();
    ind_op_t ops[7] = '{ind_inc, ind_dec, ind_add_index, ind_sub_index,
      ind_none, ind_bitrev_inc, ind_bitrev_dec};
    logic [15:0] a;
    a = 16'h0100;
    wr(3'h0, 16'h0004);
    wr(3'h3, a);
    wr(3'h5, 16'h7e01);
    arp_load = 1;
    arp_value = 3'h3;
    cyc();
    for (int i = 0; i < 7; i++) begin
      ind_op = ops[i];
      arp_load = (i == 6);
      arp_value = 3'h5;
      go(mode_indirect, 16'h0000);
      chk(data_addr_q, a);
      case (ops[i])
        ind_inc: a = a + 16'h1;
        ind_dec: a = a - 16'h1;
        ind_add_index: a = a + 16'h4;
        ind_sub_index: a = a - 16'h4;
        ind_bitrev_inc: a = rv(rv(a) + rv(16'h4));
        ind_bitrev_dec: a = rv(rv(a) - rv(16'h4));
        default: a = a;
      endcase
    end
    stop();
    chk(aux_register_pointer, 16'h5);
    ind_op = ind_none;
    go(mode_indirect, 16'h0000);
    chk(data_addr_q, 16'h7e01);
    reg_sel = 3'h3;
    go(mode_register, 16'h0000);
    chk(operand_q, a);
    reg_implied = 1;
    accumulator_buffer = 16'h5a5a;
    go(mode_register, 16'h0000);
    chk(operand_q, 16'h5a5a);
    stop();
  endtask
  // Repeat with requests pending throughout the loop
  task automatic t_rpt(input addr_mode_t m, input logic [15:0] n);
    int it, ex, ra;
    it = 0;
    ex = 0;
    ra = 0;
    irq_req = 4'hf;
    nmi_req = 1;
    is_repeat = 1;
    mem_word = (m == mode_short_imm) ? n + 16'h5 : n;
    go(m, (m == mode_short_imm) ? n : n + 16'h5);
    chk(repeat_count_register, n);
    is_repeat = 0;
    repeatable = 1;
    go(mode_direct, 16'h0001);
    instr_valid = 0;
    repeat (12) begin
      if (repeat_iter_q === 1'b1) it++;
      if (exec_q === 1'b1) ex++;
      if (repeat_active_q === 1'b1) ra++;
      if (int_mask_q === 1'b1) chk({irq_out_q, nmi_out_q}, 16'h0);
      cyc();
    end
    chk(it[15:0], n + 16'h1);
    chk(ex[15:0], n + 16'h1);
    chk(ra[15:0], n);
    chk({irq_out_q, nmi_out_q}, 16'h1f);
    repeatable = 0;
    irq_req = 4'h0;
    nmi_req = 0;
    cyc();
  endtask
  initial begin
    {rst_b, instr_valid, is_repeat, repeatable, second_valid} = '0;
    {reg_implied, arp_load, ar_wr_en, dp_load, nmi_req, irq_req} = '0;
    {instr_word, mem_word, second_word, accumulator_buffer} = '0;
    {ar_wr_data, reg_sel, arp_value, ar_wr_idx, dp_value} = '0;
    addr_mode = mode_direct;
    ind_op = ind_none;
    repeat (16) @(posedge core_clk);
    #5 rst_b = 1;
    chk(repeat_count_register, 16'h0);
    t_direct_imm();
    t_indirect();
    t_rpt(mode_short_imm, 16'h0000);
    t_rpt(mode_short_imm, 16'h0003);
    t_rpt(mode_direct, 16'h0002);
    t_rpt(mode_indirect, 16'h0001);
    tally_and_finish();
  end
endmodule // operand_addressing_and_repeat_control_tb_top
`default_nettype wire

// ### repeat_counter.sv
// Repeat count register with load and per-iteration step.
// Assumes the caller never loads and steps in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module repeat_counter
  import addressing_pkg::*;
(
  input wire logic core_clk,                      // Core clock
  input wire logic rst_b,                         // Async reset, low
  input wire logic load_en,                       // Load a new count
  input wire logic [addressing_pkg::RPT_W-1:0] load_value, // Count to load
  input wire logic step,                          // One iteration done
  output logic [addressing_pkg::RPT_W-1:0] repeat_count_register, // Count
  output logic last                               // Count has reached zero
);

  logic [RPT_W-1:0] count_q; // Remaining extra iterations
  logic [RPT_W-1:0] count_d; // Next count

  // Load wins over step; a zero count is never stepped by the caller
  always_comb begin
    count_d = count_q;
    if (load_en) begin
      count_d = load_value;
    end else if (step) begin
      count_d = count_q - RPT_STEP;
    end
  end

  // Count register, cleared by reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= RPT_COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  assign repeat_count_register = count_q;
  assign last = (count_q == RPT_COUNT_RESET);

endmodule // repeat_counter
`default_nettype wire
